// ==== design/ldo_pkg.sv ====
// package: register map, field layout and timing constants for the linear regulator control block
package ldo_pkg;
    localparam int channels = 6;
    localparam logic [7:0] ldo_control_base = 8'h6c;
    localparam logic [7:0] ldo_control_last = 8'h71;
    localparam logic [7:0] short_protect_addr = 8'h72;
    localparam logic [7:0] fault_irq_addr = 8'h73;
    localparam logic [7:0] fault_mask_addr = 8'h74;
    localparam logic [7:0] status_addr = 8'h75;
    localparam int code_lsb = 0;
    localparam int code_msb = 3;
    localparam int on_bit = 4;
    localparam int standby_keep_bit = 5;
    localparam int lowpower_bit = 6;
    localparam logic [7:0] control_write_mask = 8'h7f;
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic short_protect_reset = 1'b0;
    localparam logic [5:0] fault_mask_reset = 6'h3f;
    localparam logic [15:0] low_base_mv = 16'h0320;
    localparam logic [15:0] low_step_mv = 16'h0032;
    localparam logic [15:0] high_base_mv = 16'h0708;
    localparam logic [15:0] high_step_mv = 16'h0064;
    localparam int debounce_us = 30;
    localparam int clock_mhz = 25;
    localparam int debounce_cycles = debounce_us * clock_mhz;
    typedef enum logic [2:0]
    {
        out_off = 3'b001,
        out_on = 3'b010,
        out_lowpower = 3'b100
    } ldo_output_state_e;
endpackage

// ==== design/fault_if.sv ====
// interface: debounced fault events from the filter bank to the register logic
`timescale 1ns/1ps
interface fault_if;
    logic [5:0] fault_seen;
    modport source (output fault_seen);
    modport sink (input fault_seen);
endinterface

// ==== design/short_debounce.sv ====
// module: three-flop synchroniser and debounce counter per channel short indication
`timescale 1ns/1ps
module short_debounce
    import ldo_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [5:0] short_protect_raw,
    fault_if.source events
);
    localparam int cw = $clog2(debounce_cycles + 1);
    localparam logic [cw-1:0] limit = cw'(debounce_cycles);
    genvar g;
    generate
        for (g = 0; g < channels; g++)
        begin : chan
            logic [2:0] sync;
            logic [cw-1:0] count;
            logic [cw-1:0] next_count;
            logic stable;
            logic next_stable;
            logic pulse;
            always_comb
            begin
                next_count = count;
                next_stable = stable;
                pulse = 1'b0;
                if (sync[1] != sync[2])
                    next_count = '0;
                else if (sync[2] == stable)
                    next_count = '0;
                else if (count == limit)
                begin
                    next_stable = sync[2];
                    next_count = '0;
                    pulse = sync[2];
                end
                else
                    next_count = count + 1'b1;
            end
            always_ff @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    sync <= 3'b000;
                    count <= '0;
                    stable <= 1'b0;
                end
                else
                begin
                    sync <= {sync[1:0], short_protect_raw[g]};
                    count <= next_count;
                    stable <= next_stable;
                end
            end
            // one pulse per debounced onset, so a held short flags once [R12]
            assign events.fault_seen[g] = pulse;
        end
    endgenerate
endmodule

// ==== design/ldo_regulator_control.sv ====
// module: register bank and output decode for six linear regulators
//
// Notes on behaviour
// R1 - six channels, each with own control register
// R2 - code 3:0, on 4, keep 5, lowpower 6
// R3 - channels two to six at 0x6D-0x71
// R4 - channels one, two: 0.800-1.550 V, 50 mV
// R5 - channels three to six: 1.80-3.30 V, 100 mV
// R6 - on bit clear means output off
// R7 - on, no keep: lowpower bit selects state
// R8 - on, keep: standby picks off or lowpower
// R9 - lowpower output state forces lowest-bias mode
// R10 - disabled channel enables discharge pull-down
// R11 - processor reset low enables all pull-downs
// R12 - only debounced shorts are acted on
// R13 - debounced short with protection clears on bit
// R14 - protection bit: 0 limit, 1 shutdown
// R15 - protection bit resets cleared
// R16 - fault flag set regardless of protection
// R17 - per-channel mask gates fault interrupt
// R18 - fault flag latched until software clears
`timescale 1ns/1ps
module ldo_regulator_control
    import ldo_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic standby,
    input wire logic processor_reset_n,
    input wire logic [5:0] short_protect_raw,
    output ldo_pkg::ldo_output_state_e ldo_output_state [6],
    output logic [15:0] setpoint_mv [6],
    output logic [5:0] discharge_on,
    output logic [5:0] force_lowest_bias,
    output logic [5:0] current_limit_only,
    output logic fault_irq_n
);
    fault_if faults ();

    short_debounce filter
    (
        .clock(clock),
        .rst_b(rst_b),
        .short_protect_raw(short_protect_raw),
        .events(faults.source)
    );

    ////////////////////////////////////////////////////////////////////////
    // synchronise standby and processor reset (pins)
    logic [2:0] standby_sync;
    logic [2:0] preset_sync;
    logic standby_level;
    logic preset_low;
    logic next_standby_level;
    logic next_preset_low;

    always_comb
    begin
        next_standby_level = standby_level;
        next_preset_low = preset_low;
        if (standby_sync[1] == standby_sync[2])
            next_standby_level = standby_sync[2];
        if (preset_sync[1] == preset_sync[2])
            next_preset_low = !preset_sync[2];
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            standby_sync <= 3'b000;
            preset_sync <= 3'b000;
            standby_level <= 1'b0;
            // pull-downs stay on until the processor reset is seen released
            preset_low <= 1'b1;
        end
        else
        begin
            standby_sync <= {standby_sync[1:0], standby};
            preset_sync <= {preset_sync[1:0], processor_reset_n};
            standby_level <= next_standby_level;
            preset_low <= next_preset_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] control [6];
    logic [7:0] next_control [6];
    logic short_protect_enable;
    logic next_short_protect_enable;
    logic [5:0] ldo_fault_irq;
    logic [5:0] next_ldo_fault_irq;
    logic [5:0] ldo_fault_mask;
    logic [5:0] next_ldo_fault_mask;
    logic [7:0] next_reg_rdata;
    logic in_control;
    logic [7:0] index;

    assign in_control = (reg_addr >= ldo_control_base) && (reg_addr <= ldo_control_last); // [R3]
    assign index = reg_addr - ldo_control_base;

    always_comb
    begin
        for (int i = 0; i < channels; i++)
        begin
            next_control[i] = control[i];
            // each channel owns its register alone [R1]
            if (reg_write && in_control && index == 8'(i))
                next_control[i] = reg_wdata & control_write_mask; // [R2] [R6]
            // shutdown only when protection is on; otherwise analog limit only [R13] [R14]
            if (faults.fault_seen[i] && short_protect_enable)
                next_control[i][on_bit] = 1'b0;
        end
        next_short_protect_enable = short_protect_enable;
        if (reg_write && reg_addr == short_protect_addr)
            next_short_protect_enable = reg_wdata[0]; // [R14]
        next_ldo_fault_mask = ldo_fault_mask;
        if (reg_write && reg_addr == fault_mask_addr)
            next_ldo_fault_mask = reg_wdata[5:0];
        // write one to clear; a new event in the same cycle wins [R18]
        next_ldo_fault_irq = ldo_fault_irq;
        if (reg_write && reg_addr == fault_irq_addr)
            next_ldo_fault_irq = ldo_fault_irq & ~reg_wdata[5:0];
        next_ldo_fault_irq = next_ldo_fault_irq | faults.fault_seen; // [R12] [R16]
    end

    always_comb
    begin
        next_reg_rdata = 8'h00;
        if (in_control)
            next_reg_rdata = control[index[2:0]];
        else if (reg_addr == short_protect_addr)
            next_reg_rdata = {7'h00, short_protect_enable};
        else if (reg_addr == fault_irq_addr)
            next_reg_rdata = {2'b00, ldo_fault_irq};
        else if (reg_addr == fault_mask_addr)
            next_reg_rdata = {2'b00, ldo_fault_mask};
        else if (reg_addr == status_addr)
            next_reg_rdata = {preset_low, standby_level, faults.fault_seen};
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < channels; i++)
                control[i] <= control_reset;
            short_protect_enable <= short_protect_reset; // [R15]
            ldo_fault_irq <= 6'h00;
            ldo_fault_mask <= fault_mask_reset;
            reg_rdata <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < channels; i++)
                control[i] <= next_control[i];
            short_protect_enable <= next_short_protect_enable;
            ldo_fault_irq <= next_ldo_fault_irq;
            ldo_fault_mask <= next_ldo_fault_mask;
            reg_rdata <= next_reg_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel output decode
    ldo_output_state_e next_state [6];
    logic [15:0] next_setpoint [6];
    logic [5:0] next_discharge;
    logic [5:0] next_bias;
    logic next_irq_n;
    logic [5:0] next_limit;

    always_comb
    begin
        next_discharge = 6'h00;
        next_bias = 6'h00;
        for (int i = 0; i < channels; i++)
        begin
            if (!control[i][on_bit])
                next_state[i] = out_off; // [R6]
            else if (!control[i][standby_keep_bit])
                next_state[i] = control[i][lowpower_bit] ? out_lowpower : out_on; // [R7]
            else if (!standby_level)
                next_state[i] = out_on; // [R8]
            else
                next_state[i] = control[i][lowpower_bit] ? out_lowpower : out_off; // [R8]
            // lowest bias follows the bit while the channel is actually in low power [R9]
            next_bias[i] = (next_state[i] == out_lowpower);
            // pull-down whenever off, and for all while processor held in reset [R10] [R11]
            next_discharge[i] = (next_state[i] == out_off) || preset_low;
            if (i < 2)
                next_setpoint[i] = low_base_mv
                    + 16'(control[i][code_msb:code_lsb]) * low_step_mv; // [R4]
            else
                next_setpoint[i] = high_base_mv
                    + 16'(control[i][code_msb:code_lsb]) * high_step_mv; // [R5]
        end
        next_irq_n = !(|(ldo_fault_irq & ~ldo_fault_mask)); // [R17]
        // with protection off only the analog limiter contains a short [R14]
        next_limit = {6{!short_protect_enable}};
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < channels; i++)
            begin
                ldo_output_state[i] <= out_off;
                setpoint_mv[i] <= 16'h0000;
            end
            discharge_on <= 6'h3f;
            force_lowest_bias <= 6'h00;
            current_limit_only <= 6'h3f;
            fault_irq_n <= 1'b1;
        end
        else
        begin
            for (int i = 0; i < channels; i++)
            begin
                ldo_output_state[i] <= next_state[i];
                setpoint_mv[i] <= next_setpoint[i];
            end
            discharge_on <= next_discharge;
            force_lowest_bias <= next_bias;
            current_limit_only <= next_limit; // [R14]
            fault_irq_n <= next_irq_n;
        end
    end
endmodule

// ==== verif/fault_load.sv ====
// partner model: load side that shorts a chosen regulator output for a set time
`timescale 1ns/1ps
module fault_load
(
    input wire logic clock,
    output logic [5:0] short_protect_raw
);
    initial short_protect_raw = 6'h00;
    // hold length decides whether the short outlives the debounce
    task automatic apply(input int c, input int len);
        @(posedge clock);
        short_protect_raw[c] <= 1'b1;
        repeat (len) @(posedge clock);
        short_protect_raw[c] <= 1'b0;
    endtask
endmodule

// ==== verif/ldo_checker_sva.sv ====
// checker: port-level properties of the linear regulator control block
`timescale 1ns/1ps
module ldo_checker
    import ldo_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic processor_reset_n,
    input ldo_pkg::ldo_output_state_e ldo_output_state [6],
    input wire logic [15:0] setpoint_mv [6],
    input wire logic [5:0] discharge_on,
    input wire logic [5:0] force_lowest_bias,
    input wire logic [5:0] current_limit_only
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    AST_STATE_ONEHOT: assert property ($onehot(ldo_output_state[5]))
        else $error("output state not one-hot");
    AST_LOW_SETPOINT: assert property (reg_write && reg_addr == ldo_control_base |=>
        ##1 setpoint_mv[0] == low_base_mv + 16'($past(reg_wdata[3:0], 2)) * low_step_mv) else $error("low setpoint");
    AST_HIGH_SETPOINT: assert property (reg_write && reg_addr == ldo_control_last |=>
        ##1 setpoint_mv[5] == high_base_mv + 16'($past(reg_wdata[3:0], 2)) * high_step_mv) else $error("high setpoint");
    AST_OFF_DISCHARGE: assert property (reg_write && reg_addr == ldo_control_base && !reg_wdata[on_bit] |=>
        ##1 ldo_output_state[0] == out_off && discharge_on[0]) else $error("disabled channel not off");
    AST_BIAS_FOLLOWS: assert property (force_lowest_bias[0] == (ldo_output_state[0] == out_lowpower))
        else $error("lowest bias mismatch");
    AST_PROTECT_MODE: assert property (reg_write && reg_addr == short_protect_addr |=>
        ##1 current_limit_only == {6{!$past(reg_wdata[0], 2)}}) else $error("protection mode");
    AST_PRESET_DISCHARGE: assert property (!processor_reset_n [*7] |-> discharge_on == 6'h3f)
        else $error("discharge not on in processor reset");
    AST_CONTROL_BIT7: assert property (reg_addr >= ldo_control_base && reg_addr <= ldo_control_last |=>
        !reg_rdata[7]) else $error("control bit 7 set");
    AST_UNMAPPED_ZERO: assert property (reg_addr == 8'h80 |=> reg_rdata == 8'h00)
        else $error("unmapped read nonzero");
endmodule
bind ldo_regulator_control ldo_checker i_ldo_checker (.clock, .rst_b, .reg_addr, .reg_write, .reg_wdata,
    .reg_rdata, .processor_reset_n, .ldo_output_state, .setpoint_mv, .discharge_on, .force_lowest_bias,
    .current_limit_only);

// ==== verif/ldo_regulator_control_test.sv ====
// testbench: registers, decode, discharge and short handling of the regulator block
`timescale 1ns/1ps
`define CHK(what, e, g) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("CHECK FAILED %s expected %0h seen %0h", what, e, g); \
        end \
    end
module ldo_regulator_control_test;
    import ldo_pkg::*;
    logic clock = 0, rst_b = 0, reg_write = 0, standby = 0, processor_reset_n = 1, fault_irq_n;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, got, d;
    logic [5:0] short_protect_raw, discharge_on, force_lowest_bias, current_limit_only;
    ldo_output_state_e ldo_output_state [6];
    logic [15:0] setpoint_mv [6];
    int failures = 0, cmp_count = 0, ch;
    initial forever #20 clock = ~clock;
    ldo_regulator_control i_ldo_regulator_control (.clock, .rst_b, .reg_addr, .reg_write, .reg_wdata,
        .reg_rdata, .standby, .processor_reset_n, .short_protect_raw, .ldo_output_state, .setpoint_mv,
        .discharge_on, .force_lowest_bias, .current_limit_only, .fault_irq_n);
    fault_load i_fault_load (.clock, .short_protect_raw);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        repeat (2) @(posedge clock);
        #1 v = reg_rdata;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic [15:0] exp_mv(int c, logic [3:0] v);
        return c < 2 ? low_base_mv + 16'(v) * low_step_mv : high_base_mv + 16'(v) * high_step_mv;
    endfunction
    function automatic ldo_output_state_e exp_state(logic [7:0] v, logic s);
        if (!v[on_bit])
            return out_off;
        if (v[standby_keep_bit] && s)
            return v[lowpower_bit] ? out_lowpower : out_off;
        return (v[lowpower_bit] && !v[standby_keep_bit]) ? out_lowpower : out_on;
    endfunction
    // len above the debounce count must register; below it must vanish
    task automatic short_test(input int c, input logic prot, input logic masked, input int len);
        wr(short_protect_addr, {7'h00, prot});
        wr(fault_mask_addr, masked ? 8'h3f : 8'h00);
        wr(ldo_control_base + 8'(c), 8'h15);
        i_fault_load.apply(c, len);
        repeat (10) @(posedge clock);
        rd(fault_irq_addr, got);
        `CHK("fault flag", (len > debounce_cycles) ? 8'(1 << c) : 8'h00, got)
        rd(ldo_control_base + 8'(c), got);
        `CHK("on bit", !(prot && len > debounce_cycles), got[on_bit])
        `CHK("irq", !(len > debounce_cycles && !masked), fault_irq_n)
        `CHK("limit only", {6{!prot}}, current_limit_only)
        wr(fault_irq_addr, 8'h3f);
        rd(fault_irq_addr, got);
        `CHK("flag cleared", 8'h00, got)
        `CHK("irq released", 1'b1, fault_irq_n)
        $display("test short channel %0d done", c);
    endtask
    initial
    begin
        repeat (100000) @(posedge clock);
        failures++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(13));
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        repeat (8) @(posedge clock);
        #1;
        `CHK("limit reset", 6'h3f, current_limit_only)
        rd(short_protect_addr, got);
        `CHK("protect reset", 8'h00, got)
        rd(8'h80, got);
        `CHK("unmapped", 8'h00, got)
        $display("test reset done");
        for (int i = 0; i < 24; i++)
        begin
            ch = (i < 6) ? i : $urandom_range(5);
            d = (i == 0) ? 8'hff : (i == 1) ? 8'h80 : 8'($urandom);
            @(posedge clock);
            standby <= 1'($urandom_range(1));
            wr(ldo_control_base + 8'(ch), d);
            repeat (8) @(posedge clock);
            rd(ldo_control_base + 8'(ch), got);
            `CHK("control", d & 8'h7f, got)
            `CHK("setpoint", exp_mv(ch, d[3:0]), setpoint_mv[ch])
            `CHK("state", exp_state(d, standby), ldo_output_state[ch])
            `CHK("low bias", exp_state(d, standby) == out_lowpower, force_lowest_bias[ch])
            `CHK("discharge", exp_state(d, standby) == out_off, discharge_on[ch])
        end
        $display("test decode done");
        wr(ldo_control_base, 8'h15);
        @(posedge clock);
        processor_reset_n <= 1'b0;
        repeat (8) @(posedge clock);
        #1;
        `CHK("preset discharge", 6'h3f, discharge_on)
        rd(status_addr, got);
        `CHK("status in preset", {1'b1, standby, 6'h00}, got)
        @(posedge clock);
        processor_reset_n <= 1'b1;
        repeat (8) @(posedge clock);
        #1;
        `CHK("preset released", exp_state(8'h15, standby) == out_off, discharge_on[0])
        $display("test processor reset done");
        short_test(2, 1'b1, 1'b0, 800);
        short_test(4, 1'b0, 1'b0, 800);
        short_test(1, 1'b1, 1'b1, 800);
        short_test(5, 1'b1, 1'b0, 300);
        // protection was left on; a fresh reset must clear it again
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        `CHK("discharge in reset", 6'h3f, discharge_on)
        @(posedge clock);
        rst_b <= 1'b1;
        rd(short_protect_addr, got);
        `CHK("protect after reset", 8'h00, got)
        `CHK("limit after reset", 6'h3f, current_limit_only)
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule
